// ===== pcgc_regs.svh
/*
  register offsets, field positions, reset values and timing counts of the
  pll clock generator control block.
  assumes: included by bare name from the design modules and the testbench.
*/
`ifndef PCGC_REGS_SVH
`define PCGC_REGS_SVH

// byte offsets on the apb bus
`define PCGC_OFS_PLL_CONTROL   8'h00
`define PCGC_OFS_BANDWIDTH     8'h04
`define PCGC_OFS_SETUP         8'h08
`define PCGC_OFS_BREAK_CTRL    8'h0C

// control register fields
`define PCGC_CTL_IRQ_EN        7
`define PCGC_CTL_FLAG          6
`define PCGC_CTL_PWR_ON        5
`define PCGC_CTL_BCS           4
`define PCGC_CTL_UNUSED        4'hF

// bandwidth register fields
`define PCGC_BW_AUTO           7
`define PCGC_BW_LOCK           6
`define PCGC_BW_TRACK          5

// break control field
`define PCGC_BRK_CLR_EN        7

// reset values of the setup fields
`define PCGC_MUL_RESET         4'h6
`define PCGC_VRS_RESET         4'h6

// source clock cycles spent on each side of a switchover
`define PCGC_SWITCH_TICKS      2'h3

`endif

// ===== pcgc_pkg.sv
/*
  types shared by the pll clock generator control modules.
  assumes: nothing beyond a systemverilog compiler.
*/
`default_nettype none

package pcgc_pkg;

  // switchover sequencer states
  typedef enum logic [1:0] {
    SW_RUN = 2'b00,   // output follows the active source
    SW_OLD = 2'b01,   // draining ticks of the old source
    SW_NEW = 2'b10    // waiting ticks of the new source
  } pcgc_sw_state_t;

endpackage : pcgc_pkg

`default_nettype wire

// ===== pcgc_clk_switch.sv
/*
  base clock selector: halves the chosen source tick stream and switches
  glitch free between crystal and vco sources.
  assumes: ticks are one-cycle pulses on pclk, already synchronised.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pcgc_regs.svh"

module pcgc_clk_switch (
  input  wire logic pclk,            // system clock
  input  wire logic presetn,         // async reset, active low
  input  wire logic xtal_tick,       // crystal clock edge pulse
  input  wire logic vco_tick,        // vco clock edge pulse
  input  wire logic select_vco,      // requested source
  input  wire logic halt,            // stop mode holds output low
  output logic      base_clock_out,  // halved selected source
  output logic      switching        // output held static
);

  pcgc_pkg::pcgc_sw_state_t state_reg, state_next;
  logic       active_reg, active_next;   // source now driving the output
  logic [1:0] cnt_reg, cnt_next;         // ticks seen in this phase
  logic       out_reg, out_next;
  logic       old_tick, new_tick;

  // tick of the source in use and of the one being switched to
  assign old_tick = active_reg ? vco_tick : xtal_tick;
  assign new_tick = active_reg ? xtal_tick : vco_tick;

  // next state: output freezes while both sources settle
  always_comb begin
    state_next  = state_reg;
    active_next = active_reg;
    cnt_next    = cnt_reg;
    out_next    = out_reg;
    if (halt) begin
      // stop: output low, jump straight to the selected source
      state_next  = pcgc_pkg::SW_RUN;
      active_next = select_vco;
      cnt_next    = 2'h0;
      out_next    = 1'b0;
    end else begin
      case (state_reg)
        pcgc_pkg::SW_RUN: begin
          if (select_vco != active_reg) begin
            state_next = pcgc_pkg::SW_OLD;
            cnt_next   = 2'h0;
          end else if (old_tick) begin
            out_next = ~out_reg;
          end
        end
        pcgc_pkg::SW_OLD: begin
          if (old_tick) begin
            cnt_next = cnt_reg + 2'h1;
            if (cnt_reg == `PCGC_SWITCH_TICKS - 2'h1) begin  // [RULE_25]
              state_next = pcgc_pkg::SW_NEW;
              cnt_next   = 2'h0;
            end
          end
        end
        pcgc_pkg::SW_NEW: begin
          if (new_tick) begin
            cnt_next = cnt_reg + 2'h1;
            if (cnt_reg == `PCGC_SWITCH_TICKS - 2'h1) begin  // [RULE_25]
              state_next  = pcgc_pkg::SW_RUN;
              active_next = ~active_reg;
              cnt_next    = 2'h0;
            end
          end
        end
        default: begin
          state_next = pcgc_pkg::SW_RUN;
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= pcgc_pkg::SW_RUN;
      active_reg <= 1'b0;
      cnt_reg    <= 2'h0;
      out_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      active_reg <= active_next;
      cnt_reg    <= cnt_next;
      out_reg    <= out_next;
    end
  end

  assign base_clock_out = out_reg;
  assign switching      = (state_reg != pcgc_pkg::SW_RUN);

  // output does not move during a switchover unless stop halts it
  a_switch_static: assert property (  // [RULE_25]
    @(posedge pclk) disable iff (!presetn)
    switching && !halt |=> $stable(base_clock_out))
    else $error("base clock moved during switchover");

  c_switch_done: cover property (
    @(posedge pclk) disable iff (!presetn)
    $fell(switching) && active_reg);

endmodule : pcgc_clk_switch

`default_nettype wire

// ===== pcgc_top.sv
/*
  pll clock generator control: apb registers, write protection, lock change
  flag and interrupt, stop and break handling, base clock selection.
  assumes: analog pll status and source clocks arrive as asynchronous pins;
  stop_mode and break_state come from pclk logic.
  // Contract
  // RULE_01 - multiplier zero acts as one
  // RULE_02 - multiplier one to fifteen used directly
  // RULE_03 - multiplier resets to six
  // RULE_04 - multiplier writes ignored while pll on
  // RULE_05 - range writes ignored while pll on
  // RULE_06 - range zero disables pll, clears select
  // RULE_07 - range zero refuses setting source select
  // RULE_08 - range resets to six
  // RULE_09 - auto mode flags every lock change
  // RULE_10 - manual mode: no irq, flag reads zero
  // RULE_11 - software reads lock after interrupt
  // RULE_12 - select settable even while unlocked
  // RULE_13 - software confirms lock before selecting
  // RULE_14 - generator keeps running in wait mode
  // RULE_15 - software may power pll off before wait
  // RULE_16 - stop drives crystal, base, irq low
  // RULE_17 - stop clears source select, stays clear
  // RULE_18 - break clears stick when clear enabled
  // RULE_19 - break protects flag when clear disabled
  // RULE_20 - tracking bit marks acquisition end
  // RULE_21 - lock bit marks lock time end
  // RULE_22 - control read or reset clears flag
  // RULE_23 - power on not clearable while selected
  // RULE_24 - select not settable while power off
  // RULE_25 - switchover waits three ticks each side
*/
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "pcgc_regs.svh"

module pcgc_top (
  input  wire logic        pclk,               // 40 MHz bus clock
  input  wire logic        presetn,            // async reset, active low
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        crystal_clock,      // crystal pin, async
  input  wire logic        vco_clock,          // vco pin, async
  input  wire logic        pll_lock_raw,       // analog lock detector
  input  wire logic        pll_track_raw,      // analog tracking status
  input  wire logic        stop_mode,          // stop instruction active
  input  wire logic        break_state,        // debugger break active
  output logic             crystal_clock_out,  // gated crystal clock
  output logic             base_clock_out,     // halved selected source
  output logic             pll_irq_line,       // lock change interrupt
  output logic             pll_enable,         // analog pll run
  output logic             manual_track,       // manual tracking request
  output logic             auto_bandwidth,     // automatic mode select
  output logic [3:0]       feedback_divisor,   // vco multiplier n
  output logic [3:0]       vco_range_select,   // range multiplier l
  output logic             clock_switching     // base clock frozen
);

  // multiplier field to divider modulus, zero acting as one
  function automatic logic [3:0] mul_to_n(input logic [3:0] m);
    mul_to_n = (m == 4'h0) ? 4'h1 : m;  // [RULE_01] [RULE_02]
  endfunction : mul_to_n

  // register state
  logic       irq_en_reg, irq_en_next;
  logic       flag_reg, flag_next;
  logic       pwr_on_reg, pwr_on_next;
  logic       bcs_reg, bcs_next;
  logic       auto_reg, auto_next;
  logic       acq_man_reg, acq_man_next;   // manual tracking value kept
  logic [3:0] mul_reg, mul_next;
  logic [3:0] vrs_reg, vrs_next;
  logic       break_flag_clear_enable_reg, break_flag_clear_enable_next;
  logic [31:0] rdata_reg, rdata_next;
  logic       cap_flag_reg, cap_flag_next; // flag value handed to reader

  // pin synchronisers: stage one is read only by stage two
  logic [3:0] sync1_reg, sync2_reg, prev_reg;
  logic       lock_s, track_s, xtal_s, vco_s;
  logic       lock_change, xtal_tick, vco_tick;

  // bus decode
  logic setup, wr_acc, rd_acc, hit;
  logic wr_ctl, wr_bw, wr_setup, wr_brk, rd_ctl;
  logic flag_clear_ok, flag_vis;

  // two-flop sync of asynchronous pins, third stage for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      prev_reg  <= 4'h0;
    end else begin
      sync1_reg <= {vco_clock, crystal_clock, pll_track_raw, pll_lock_raw};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign lock_s      = sync2_reg[0];
  assign track_s     = sync2_reg[1];
  assign xtal_s      = sync2_reg[2];
  assign vco_s       = sync2_reg[3];
  // lock toggles in either direction count as a change
  assign lock_change = auto_reg && (sync2_reg[0] != prev_reg[0]);  // [RULE_09]
  assign xtal_tick   = xtal_s && !prev_reg[2];
  // no vco edges while the pll is disabled
  assign vco_tick    = vco_s && !prev_reg[3] && pll_enable;

  // apb decode; the slave always answers without wait states
  assign setup    = psel && !penable;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_acc   = psel && penable && !pwrite;
  assign hit      = (paddr == `PCGC_OFS_PLL_CONTROL) || (paddr == `PCGC_OFS_BANDWIDTH) ||
                    (paddr == `PCGC_OFS_SETUP) || (paddr == `PCGC_OFS_BREAK_CTRL);
  assign wr_ctl   = wr_acc && (paddr == `PCGC_OFS_PLL_CONTROL);
  assign wr_bw    = wr_acc && (paddr == `PCGC_OFS_BANDWIDTH);
  assign wr_setup = wr_acc && (paddr == `PCGC_OFS_SETUP);
  assign wr_brk   = wr_acc && (paddr == `PCGC_OFS_BREAK_CTRL);
  assign rd_ctl   = rd_acc && (paddr == `PCGC_OFS_PLL_CONTROL);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit;

  // reads may clear the flag unless a break protects it
  assign flag_clear_ok = !(break_state && !break_flag_clear_enable_reg);  // [RULE_18] [RULE_19]
  // manual mode hides the flag from software
  assign flag_vis      = flag_reg && auto_reg;  // [RULE_10]

  // next values of the control and setup state
  always_comb begin
    irq_en_next   = irq_en_reg;
    flag_next     = flag_reg;
    pwr_on_next   = pwr_on_reg;
    bcs_next      = bcs_reg;
    auto_next     = auto_reg;
    acq_man_next  = acq_man_reg;
    mul_next      = mul_reg;
    vrs_next      = vrs_reg;
    break_flag_clear_enable_next     = break_flag_clear_enable_reg;
    rdata_next    = rdata_reg;
    cap_flag_next = cap_flag_reg;
    if (wr_ctl) begin
      // enable writable only in automatic mode
      if (auto_reg) begin
        irq_en_next = pwdata[`PCGC_CTL_IRQ_EN];
      end
      // power cannot be turned off while the vco is already selected
      if (pwdata[`PCGC_CTL_PWR_ON] || !bcs_reg) begin  // [RULE_23]
        pwr_on_next = pwdata[`PCGC_CTL_PWR_ON];
      end
      // select needs power already on and a nonzero range; lock is not
      // checked, so an unlocked vco may be chosen
      if (!pwdata[`PCGC_CTL_BCS] || (pwr_on_reg && vrs_reg != 4'h0)) begin  // [RULE_24] [RULE_07] [RULE_12]
        bcs_next = pwdata[`PCGC_CTL_BCS];
      end
    end
    if (wr_bw) begin
      auto_next = pwdata[`PCGC_BW_AUTO];
      // tracking bit is only writable in manual mode
      if (!auto_reg) begin
        acq_man_next = pwdata[`PCGC_BW_TRACK];
      end
    end
    // setup fields locked while the pll power on bit is set
    if (wr_setup && !pwr_on_reg) begin  // [RULE_04] [RULE_05]
      mul_next = pwdata[7:4];
      vrs_next = pwdata[3:0];
    end
    if (wr_brk) begin
      break_flag_clear_enable_next = pwdata[`PCGC_BRK_CLR_EN];
    end
    // zero range or stop drops the vco selection
    if (vrs_reg == 4'h0 || stop_mode) begin  // [RULE_06] [RULE_17]
      bcs_next = 1'b0;
    end
    if (!auto_next) begin
      irq_en_next = 1'b0;
    end
    // clear only what the reader saw; a new change always wins
    if (rd_ctl && flag_clear_ok && cap_flag_reg) begin  // [RULE_22]
      flag_next = 1'b0;
    end
    if (lock_change) begin  // [RULE_09]
      flag_next = 1'b1;
    end
    // read data is captured in the setup cycle
    if (setup) begin
      cap_flag_next = flag_vis;
      case (paddr)
        `PCGC_OFS_PLL_CONTROL: rdata_next = {24'h0, irq_en_reg, flag_vis, pwr_on_reg,
                                             bcs_reg, `PCGC_CTL_UNUSED};
        // lock and tracking report the analog status in auto mode
        `PCGC_OFS_BANDWIDTH:   rdata_next = {24'h0, auto_reg, lock_s && auto_reg,
                                             auto_reg ? track_s : acq_man_reg,
                                             5'h00};  // [RULE_20] [RULE_21]
        `PCGC_OFS_SETUP:       rdata_next = {24'h0, mul_reg, vrs_reg};
        `PCGC_OFS_BREAK_CTRL:  rdata_next = {24'h0, break_flag_clear_enable_reg, 7'h00};
        default:               rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // control and setup registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg   <= 1'b0;
      flag_reg     <= 1'b0;                // [RULE_22]
      pwr_on_reg   <= 1'b1;                // loop settles during power up
      bcs_reg      <= 1'b0;
      auto_reg     <= 1'b0;
      acq_man_reg  <= 1'b0;
      mul_reg      <= `PCGC_MUL_RESET;     // [RULE_03]
      vrs_reg      <= `PCGC_VRS_RESET;     // [RULE_08]
      break_flag_clear_enable_reg     <= 1'b0;
      rdata_reg    <= 32'h0000_0000;
      cap_flag_reg <= 1'b0;
    end else begin
      irq_en_reg   <= irq_en_next;
      flag_reg     <= flag_next;
      pwr_on_reg   <= pwr_on_next;
      bcs_reg      <= bcs_next;
      auto_reg     <= auto_next;
      acq_man_reg  <= acq_man_next;
      mul_reg      <= mul_next;
      vrs_reg      <= vrs_next;
      break_flag_clear_enable_reg     <= break_flag_clear_enable_next;
      rdata_reg    <= rdata_next;
      cap_flag_reg <= cap_flag_next;
    end
  end

  // gated crystal clock copy, low during stop
  logic xclk_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xclk_reg <= 1'b0;
    end else begin
      xclk_reg <= xtal_s && !stop_mode;  // [RULE_16]
    end
  end

  // base clock selector; wait mode has no effect on it
  pcgc_clk_switch u_switch (  // [RULE_14]
    .pclk           (pclk),
    .presetn        (presetn),
    .xtal_tick      (xtal_tick),
    // a powered-off vco gives no edges, so its drain must not wait for them
    .vco_tick       (vco_tick || !pll_enable),
    .select_vco     (bcs_reg),
    .halt           (stop_mode),  // [RULE_16]
    .base_clock_out (base_clock_out),
    .switching      (clock_switching)
  );

  // outputs; interrupt gated off in manual mode and stop
  assign prdata            = rdata_reg;
  assign crystal_clock_out = xclk_reg;
  assign pll_irq_line      = flag_vis && irq_en_reg && !stop_mode;  // [RULE_10] [RULE_16]
  assign pll_enable        = pwr_on_reg && (vrs_reg != 4'h0)  // [RULE_06]
                             && !stop_mode;                   // [RULE_16]
  assign manual_track      = acq_man_reg;
  assign auto_bandwidth    = auto_reg;
  assign feedback_divisor  = mul_to_n(mul_reg);
  assign vco_range_select  = vrs_reg;

  a_mul_zero_one: assert property (  // [RULE_01]
    @(posedge pclk) disable iff (!presetn)
    mul_reg == 4'h0 |-> feedback_divisor == 4'h1)
    else $error("zero multiplier not treated as one");

  a_setup_locked: assert property (  // [RULE_04]
    @(posedge pclk) disable iff (!presetn)
    wr_setup && pwr_on_reg |=> $stable(mul_reg) && $stable(vrs_reg))
    else $error("setup field written while pll on");

  a_range_zero_bcs: assert property (  // [RULE_07]
    @(posedge pclk) disable iff (!presetn)
    vrs_reg == 4'h0 |=> !bcs_reg)
    else $error("vco selected with zero range");

  a_flag_on_change: assert property (  // [RULE_09]
    @(posedge pclk) disable iff (!presetn)
    lock_change |=> flag_reg)
    else $error("lock change did not set flag");

  a_manual_quiet: assert property (  // [RULE_10]
    @(posedge pclk) disable iff (!presetn)
    !auto_reg |-> !pll_irq_line && !flag_vis)
    else $error("flag or irq visible in manual mode");

  a_read_clears: assert property (  // [RULE_22]
    @(posedge pclk) disable iff (!presetn)
    rd_ctl && cap_flag_reg && flag_clear_ok && !lock_change |=> !flag_reg)
    else $error("control read did not clear flag");

  a_break_protect: assert property (  // [RULE_19]
    @(posedge pclk) disable iff (!presetn)
    rd_ctl && break_state && !break_flag_clear_enable_reg && flag_reg |=> flag_reg)
    else $error("flag cleared during protected break");

  a_power_held: assert property (  // [RULE_23]
    @(posedge pclk) disable iff (!presetn)
    bcs_reg |=> pwr_on_reg)
    else $error("power dropped while vco selected");

  a_stop_low: assert property (  // [RULE_16]
    @(posedge pclk) disable iff (!presetn)
    stop_mode ##1 stop_mode |-> !pll_irq_line && !crystal_clock_out && !base_clock_out)
    else $error("outputs not low in stop");

  a_stop_bcs: assert property (  // [RULE_17]
    @(posedge pclk) disable iff (!presetn)
    stop_mode |=> !bcs_reg)
    else $error("stop left vco selected");

  c_flag_set:   cover property (@(posedge pclk) disable iff (!presetn) $rose(flag_reg));
  c_bcs_set:    cover property (@(posedge pclk) disable iff (!presetn) $rose(bcs_reg));
  c_irq:        cover property (@(posedge pclk) disable iff (!presetn) pll_irq_line);
  c_stop_clear: cover property (@(posedge pclk) disable iff (!presetn) stop_mode && bcs_reg);

endmodule : pcgc_top

`default_nettype wire

// ===== tb.sv
/*
  self-checking testbench of the pll clock generator control block.
  assumes: pcgc_top and its package and header are compiled first; apb slave
  answers with pready high, source clocks are slow compared with pclk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pcgc_regs.svh"

module tb;
  logic        pclk          = 1'b0;   // 40 MHz bus clock
  logic        presetn       = 1'b0;   // async reset, active low
  logic        psel          = 1'b0;   // apb select
  logic        penable       = 1'b0;   // apb access phase
  logic        pwrite        = 1'b0;   // apb direction
  logic [7:0]  paddr         = 8'h00;  // apb byte address
  logic [31:0] pwdata        = 32'h0;  // apb write data
  logic        pll_lock_raw  = 1'b0;   // analog lock level
  logic        pll_track_raw = 1'b0;   // analog tracking level
  logic        stop_mode     = 1'b0;   // stop instruction level
  logic        break_state   = 1'b0;   // debugger break level
  logic [2:0]  xcnt          = 3'h0;   // crystal divider, period 8 pclk
  logic [2:0]  vcnt          = 3'h0;   // vco divider, period 6 pclk
  logic [31:0] prdata;                 // apb read data
  logic        pready, pslverr;        // apb answer
  logic        crystal_clock_out, base_clock_out, pll_irq_line, pll_enable;
  logic        manual_track, auto_bandwidth, clock_switching;
  logic [3:0]  feedback_divisor, vco_range_select;
  int          mismatches    = 0;      // failed comparisons
  int          check_count   = 0;      // comparisons made
  int          cycles        = 0;      // timeout counter

  pcgc_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crystal_clock(xcnt[2]),
    .vco_clock(vcnt < 3'h3), .pll_lock_raw(pll_lock_raw),
    .pll_track_raw(pll_track_raw), .stop_mode(stop_mode),
    .break_state(break_state), .crystal_clock_out(crystal_clock_out),
    .base_clock_out(base_clock_out), .pll_irq_line(pll_irq_line),
    .pll_enable(pll_enable), .manual_track(manual_track),
    .auto_bandwidth(auto_bandwidth), .feedback_divisor(feedback_divisor),
    .vco_range_select(vco_range_select), .clock_switching(clock_switching)
  );

  // bus clock, half period 12.5 ns
  initial begin
    forever #12.5 pclk = ~pclk;
  end

  // source clocks derived on pclk so they move off the sampling instant
  always @(posedge pclk) begin
    xcnt <= xcnt + 3'h1;
    vcnt <= (vcnt == 3'h5) ? 3'h0 : vcnt + 3'h1;
  end

  // hang guard: the whole sequence needs well under 5000 cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      close_out();
    end
  end

  task automatic close_out();
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  // one apb transfer; held until pready is seen high with the access phase
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    xfer(a, 1'b1, {24'h0, d}, r, e);
    // one more edge so the written state has settled before it is looked at
    @(posedge pclk);
  endtask : wr

  // read and compare one register in a single call
  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    xfer(a, 1'b0, 32'h0, r, e);
    check(name, r, {24'h0, exp});
  endtask : rd

  // lets a pin change pass the synchronisers and the edge detector
  task automatic settle();
    repeat (8) @(posedge pclk);
  endtask : settle

  task automatic t_reset();
    check("divisor", feedback_divisor, 4'h6);
    check("range", vco_range_select, 4'h6);
    rd("setup", `PCGC_OFS_SETUP, 8'h66);
    rd("control", `PCGC_OFS_PLL_CONTROL, 8'h2F);
    rd("bandwidth", `PCGC_OFS_BANDWIDTH, 8'h00);
  endtask : t_reset

  // setup writes bounce while powered, every multiplier code when off
  task automatic t_setup();
    wr(`PCGC_OFS_SETUP, 8'h12);
    rd("setup", `PCGC_OFS_SETUP, 8'h66);
    wr(`PCGC_OFS_PLL_CONTROL, 8'h00);
    for (int i = 0; i < 16; i++) begin
      wr(`PCGC_OFS_SETUP, {i[3:0], 4'h6});
      check("divisor", feedback_divisor, (i == 0) ? 4'h1 : i[3:0]);
    end
    wr(`PCGC_OFS_SETUP, 8'h66);
  endtask : t_setup

  // select interlocks and the frozen switchover window
  task automatic t_select();
    int   n;
    logic b;
    logic held;
    wr(`PCGC_OFS_PLL_CONTROL, 8'h10);
    rd("control", `PCGC_OFS_PLL_CONTROL, 8'h0F);
    wr(`PCGC_OFS_PLL_CONTROL, 8'h20);
    wr(`PCGC_OFS_PLL_CONTROL, 8'h30);
    rd("control", `PCGC_OFS_PLL_CONTROL, 8'h3F);
    n = 0;
    while (clock_switching !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    check("switching", clock_switching, 1'b1);
    b = base_clock_out;
    held = 1'b1;
    n = 0;
    while (clock_switching === 1'b1 && n < 300) begin
      @(posedge pclk);
      if (clock_switching === 1'b1 && base_clock_out !== b) held = 1'b0;
      n++;
    end
    check("held", held, 1'b1);
    check("switching", clock_switching, 1'b0);
    wr(`PCGC_OFS_PLL_CONTROL, 8'h10);
    rd("control", `PCGC_OFS_PLL_CONTROL, 8'h3F);
    wr(`PCGC_OFS_PLL_CONTROL, 8'h00);
    wr(`PCGC_OFS_PLL_CONTROL, 8'h00);
    check("enable", pll_enable, 1'b0);
    wr(`PCGC_OFS_SETUP, 8'h60);
    wr(`PCGC_OFS_PLL_CONTROL, 8'h20);
    check("enable", pll_enable, 1'b0);
    repeat (40) @(posedge pclk);
    check("switching", clock_switching, 1'b0);
    wr(`PCGC_OFS_PLL_CONTROL, 8'h30);
    rd("control", `PCGC_OFS_PLL_CONTROL, 8'h2F);
    wr(`PCGC_OFS_PLL_CONTROL, 8'h00);
    wr(`PCGC_OFS_SETUP, 8'h66);
    wr(`PCGC_OFS_PLL_CONTROL, 8'h20);
    check("enable", pll_enable, 1'b1);
  endtask : t_select

  // lock change flag, interrupt and status bits in both bandwidth modes
  task automatic t_irq();
    wr(`PCGC_OFS_BANDWIDTH, 8'h80);
    wr(`PCGC_OFS_PLL_CONTROL, 8'hA0);
    pll_lock_raw <= 1'b1;
    settle();
    check("irq", pll_irq_line, 1'b1);
    rd("bandwidth", `PCGC_OFS_BANDWIDTH, 8'hC0);
    pll_track_raw <= 1'b1;
    settle();
    rd("bandwidth", `PCGC_OFS_BANDWIDTH, 8'hE0);
    rd("control", `PCGC_OFS_PLL_CONTROL, 8'hEF);
    rd("control", `PCGC_OFS_PLL_CONTROL, 8'hAF);
    check("irq", pll_irq_line, 1'b0);
    wr(`PCGC_OFS_PLL_CONTROL, 8'h20);
    pll_lock_raw <= 1'b0;
    settle();
    check("irq", pll_irq_line, 1'b0);
    wr(`PCGC_OFS_BANDWIDTH, 8'h00);
    check("auto", auto_bandwidth, 1'b0);
    rd("control", `PCGC_OFS_PLL_CONTROL, 8'h2F);
    wr(`PCGC_OFS_BANDWIDTH, 8'h80);
    rd("control", `PCGC_OFS_PLL_CONTROL, 8'h6F);
    wr(`PCGC_OFS_BANDWIDTH, 8'h00);
    wr(`PCGC_OFS_BANDWIDTH, 8'h20);
    check("manual track", manual_track, 1'b1);
    pll_lock_raw <= 1'b1;
    settle();
    check("irq", pll_irq_line, 1'b0);
    rd("control", `PCGC_OFS_PLL_CONTROL, 8'h2F);
    rd("bandwidth", `PCGC_OFS_BANDWIDTH, 8'h20);
  endtask : t_irq

  // break protection of the flag, then clears that stick
  task automatic t_break();
    wr(`PCGC_OFS_BANDWIDTH, 8'h80);
    wr(`PCGC_OFS_PLL_CONTROL, 8'hA0);
    pll_lock_raw <= 1'b0;
    settle();
    break_state <= 1'b1;
    rd("control", `PCGC_OFS_PLL_CONTROL, 8'hEF);
    wr(`PCGC_OFS_PLL_CONTROL, 8'hA0);
    rd("control", `PCGC_OFS_PLL_CONTROL, 8'hEF);
    wr(`PCGC_OFS_BREAK_CTRL, 8'h80);
    rd("control", `PCGC_OFS_PLL_CONTROL, 8'hEF);
    rd("control", `PCGC_OFS_PLL_CONTROL, 8'hAF);
    break_state <= 1'b0;
    rd("control", `PCGC_OFS_PLL_CONTROL, 8'hAF);
    wr(`PCGC_OFS_BREAK_CTRL, 8'h00);
  endtask : t_break

  // stop with the vco selected and an interrupt pending
  task automatic t_stop();
    logic [31:0] r;
    logic        e;
    pll_lock_raw <= 1'b1;
    settle();
    rd("bandwidth", `PCGC_OFS_BANDWIDTH, 8'hE0);
    wr(`PCGC_OFS_PLL_CONTROL, 8'hB0);
    check("irq", pll_irq_line, 1'b1);
    stop_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    check("crystal out", crystal_clock_out, 1'b0);
    check("base out", base_clock_out, 1'b0);
    check("enable", pll_enable, 1'b0);
    check("irq", pll_irq_line, 1'b0);
    stop_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    xfer(`PCGC_OFS_PLL_CONTROL, 1'b0, 32'h0, r, e);
    check("select", r[`PCGC_CTL_BCS], 1'b0);
  endtask : t_stop

  // unmapped address answers with an error and zero data
  task automatic t_unmapped();
    logic [31:0] r;
    logic        e;
    xfer(8'h10, 1'b0, 32'h0, r, e);
    check("error", e, 1'b1);
    check("read data", r, 32'h0);
  endtask : t_unmapped

  // main sequence: reset for 4 cycles, then each scenario in turn
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_setup();
    t_select();
    t_irq();
    t_break();
    t_stop();
    t_unmapped();
    close_out();
  end
endmodule : tb
`default_nettype wire
